// *** boot_bus_pkg.sv ***
package boot_bus_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFFS_CTRL = 8'h00;
  localparam logic [7:0] OFFS_STATUS = 8'h04;
  localparam int CTRL_PAGE_LSB = 0;
  localparam int CTRL_WAIT_LSB = 3;
  localparam int CTRL_FORCE_BIT = 6;
  localparam int STAT_BOOTING_BIT = 0;
  localparam int STAT_GRANTED_BIT = 1;
  localparam int STAT_RELOC_BIT = 2;
  localparam int STAT_ILLEGAL_BIT = 3;
  localparam int STAT_WORD_LSB = 16;
  localparam logic [2:0] BOOT_PAGE_RESET = 3'h0;
  localparam logic [2:0] BOOT_WAIT_RESET = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // boot timing and memory map
  // ----------------------------------------------------------------
  localparam logic [3:0] ACCESS_EXTRA = 4'h3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [1:0] LAST_BYTE_SEL = 2'h2;
  localparam logic [2:0] LEN_WORD_FILL = 3'h7;
  localparam logic [23:0] BOOT_HI_OE = 24'hc00000;
  localparam logic [13:0] PRAM_BASE_LOW = 14'h0000;
  localparam logic [13:0] PRAM_BASE_HIGH = 14'h3800;
  localparam logic [13:0] RESET_VECTOR = 14'h0000;
  localparam int SYNC_W = 27;
  localparam logic [26:0] SYNC_RESET = 27'h4000000;

  typedef enum logic [3:0] {
    B_IDLE = 4'b0001,
    B_GAP = 4'b0010,
    B_ACCESS = 4'b0100,
    B_WRITE = 4'b1000
  } boot_state_type;

  typedef struct packed {
    logic [13:0] addr;
    logic [23:0] data;
    logic [23:0] dataOe;
    logic progSel;
    logic dataSel;
    logic rd;
    logic wr;
  } core_bus_type;

  typedef struct packed {
    logic [13:0] addr;
    logic [23:0] data;
    logic bootSel_n;
    logic progSel_n;
    logic dataSel_n;
    logic rd_n;
    logic wr_n;
  } ext_bus_type;

endpackage : boot_bus_pkg

// *** bit_sync.sv ***
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : bit_sync

// *** eprom_boot_and_bus_grant.sv ***
// What this block does
// - page length gives (words/8)-1, zero means eight
// - eight 8k pages, byte0 length, gaps, triplets
// - length byte first, then load top downward
// - both straps low select byte-wide boot
// - strap boot after reset always uses page zero
// - write page, set force bit, boot starts
// - wait field 0..7, resets to seven
// - boot access times like external, boot strobe
// - 16-bit address: A13..A0 plus D23,D22
// - boot byte sampled from D15..D8
// - map strap high with boot strap low relocates RAM, start 0x0000
// - idle request granted next cycle, bus floats
// - go mode runs internally until external access
// - grant keeps core state, serial ports run
// - busy access finishes first, then grant
// - request removal drops grant same cycle
// - grant also works in reset and boot
// - boot byte completes before grant
// - hang flags blocked core while granted
`timescale 1ns/1ps
module eprom_boot_and_bus_grant (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic memoryMapSelect,
  input wire logic bootModeSelect,
  input wire logic busRequest_n,
  input wire logic [23:0] extDataIn,
  input wire logic coreReset,
  input wire logic goModeEnable,
  input wire logic extAccessReq,
  input wire logic extAccessBusy,
  input wire boot_bus_pkg::core_bus_type coreBus,
  output boot_bus_pkg::ext_bus_type extBus,
  output logic [23:0] extDataOe,
  output logic busDriveOe,
  output logic busGrant_n,
  output logic busGrantHang_n,
  output logic coreHalt,
  output logic extAccessAllow,
  output logic pramWrite,
  output logic [10:0] pramAddr,
  output logic [23:0] pramData,
  output logic pramRelocated,
  output logic [13:0] pramBase,
  output logic [13:0] resetVector,
  output logic booting
);

  // ----------------------------------------------------------------
  // byte address of a boot byte within the 64k boot space
  // ----------------------------------------------------------------
  function automatic logic [15:0] bootAddr(input logic [2:0] page, input logic lenByte,
                                           input logic [10:0] word, input logic [1:0] sel);
    logic [15:0] base;
    base = {page, 13'h0000};
    if (lenByte) begin
      bootAddr = base;
    end else begin
      bootAddr = base + {3'h0, word, 2'h0} + {14'h0, sel} + 16'h0001;
    end
  endfunction : bootAddr

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [26:0] syncOut;

  bit_sync #(
    .WIDTH(boot_bus_pkg::SYNC_W),
    .RESET_VAL(boot_bus_pkg::SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({busRequest_n, memoryMapSelect, bootModeSelect, extDataIn}),
    .dout(syncOut)
  );

  wire reqActive = ~syncOut[26];
  wire strapMap = syncOut[25];
  wire strapBoot = syncOut[24];
  wire [7:0] bootByte = syncOut[15:8];

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  logic [1:0] settleCnt;
  logic strapsTaken;
  logic mapStrap;
  logic bootStrap;

  wire settled = settleCnt == boot_bus_pkg::STRAP_SETTLE;
  wire strapStart = ~strapsTaken & settled & ~strapMap & ~strapBoot;
  // illegal straps are only flagged, the board must never build them
  wire strapIllegal = bootStrap & ~mapStrap;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt <= 2'h0;
      strapsTaken <= 1'b0;
      mapStrap <= 1'b0;
      bootStrap <= 1'b0;
    end else if (!strapsTaken) begin
      settleCnt <= settled ? settleCnt : settleCnt + 2'h1;
      strapsTaken <= settled;
      mapStrap <= strapMap;
      bootStrap <= strapBoot;
    end
  end

  assign pramRelocated = mapStrap & ~bootStrap;
  assign pramBase = pramRelocated ? boot_bus_pkg::PRAM_BASE_HIGH : boot_bus_pkg::PRAM_BASE_LOW;
  assign resetVector = boot_bus_pkg::RESET_VECTOR;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [2:0] bootPage;
  logic [2:0] bootWait;
  logic forceReq;
  logic grantReg;
  logic busGranted;
  boot_bus_pkg::boot_state_type bootState;
  logic [10:0] wordIdx;

  wire wrFire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire wrCtrl = wrFire & (s_axi_awaddr == boot_bus_pkg::OFFS_CTRL);
  wire wrKnown = wrCtrl | (s_axi_awaddr == boot_bus_pkg::OFFS_STATUS);
  wire wrLow = wrCtrl & s_axi_wstrb[0];
  wire rdFire = s_axi_arvalid & ~s_axi_rvalid;
  wire rdCtrl = s_axi_araddr == boot_bus_pkg::OFFS_CTRL;
  wire rdStatus = s_axi_araddr == boot_bus_pkg::OFFS_STATUS;
  wire [31:0] ctrlWord = {26'h0, bootWait, bootPage};
  wire [31:0] statusWord = {5'h0, wordIdx, 12'h0, strapIllegal, pramRelocated, busGranted, booting};
  wire [31:0] readWord = rdCtrl ? ctrlWord : (rdStatus ? statusWord : 32'h0);

  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bootPage <= boot_bus_pkg::BOOT_PAGE_RESET;
      bootWait <= boot_bus_pkg::BOOT_WAIT_RESET;
      forceReq <= 1'b0;
    end else begin
      if (wrLow) begin
        bootPage <= s_axi_wdata[boot_bus_pkg::CTRL_PAGE_LSB +: 3];
        bootWait <= s_axi_wdata[boot_bus_pkg::CTRL_WAIT_LSB +: 3];
      end
      forceReq <= wrLow & s_axi_wdata[boot_bus_pkg::CTRL_FORCE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= boot_bus_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= boot_bus_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? boot_bus_pkg::RESP_OKAY : boot_bus_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= (rdCtrl | rdStatus) ? boot_bus_pkg::RESP_OKAY : boot_bus_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // boot sequencer
  // ----------------------------------------------------------------
  logic [2:0] curPage;
  logic lenPhase;
  logic [1:0] byteSel;
  logic [3:0] accCnt;
  logic [23:0] wordBuf;

  wire inIdle = bootState == boot_bus_pkg::B_IDLE;
  wire inGap = bootState == boot_bus_pkg::B_GAP;
  wire inAccess = bootState == boot_bus_pkg::B_ACCESS;
  wire inWrite = bootState == boot_bus_pkg::B_WRITE;
  wire startBoot = strapStart | (forceReq & inIdle);
  wire [2:0] startPage = strapStart ? boot_bus_pkg::BOOT_PAGE_RESET : bootPage;
  // a new byte never starts while a request is pending or granted
  wire canStart = ~reqActive & ~grantReg;
  wire byteDone = accCnt == 4'h0;
  wire [15:0] byteAddr = bootAddr(curPage, lenPhase, wordIdx, byteSel);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bootState <= boot_bus_pkg::B_IDLE;
      curPage <= boot_bus_pkg::BOOT_PAGE_RESET;
      lenPhase <= 1'b0;
      wordIdx <= 11'h0;
      byteSel <= 2'h0;
      accCnt <= 4'h0;
      wordBuf <= 24'h0;
    end else begin
      unique case (bootState)
        boot_bus_pkg::B_IDLE: begin
          if (startBoot) begin
            curPage <= startPage;
            lenPhase <= 1'b1;
            bootState <= boot_bus_pkg::B_GAP;
          end
        end
        boot_bus_pkg::B_GAP: begin
          if (canStart) begin
            accCnt <= {1'b0, bootWait} + boot_bus_pkg::ACCESS_EXTRA;
            bootState <= boot_bus_pkg::B_ACCESS;
          end
        end
        boot_bus_pkg::B_ACCESS: begin
          if (!byteDone) begin
            accCnt <= accCnt - 4'h1;
          end else if (lenPhase) begin
            lenPhase <= 1'b0;
            wordIdx <= {bootByte, boot_bus_pkg::LEN_WORD_FILL};
            byteSel <= boot_bus_pkg::LAST_BYTE_SEL;
            bootState <= boot_bus_pkg::B_GAP;
          end else begin
            // bytes come highest address first, so the lowest lands on top
            wordBuf <= {bootByte, wordBuf[23:8]};
            byteSel <= byteSel - 2'h1;
            bootState <= (byteSel == 2'h0) ? boot_bus_pkg::B_WRITE : boot_bus_pkg::B_GAP;
          end
        end
        boot_bus_pkg::B_WRITE: begin
          wordIdx <= wordIdx - 11'h1;
          byteSel <= boot_bus_pkg::LAST_BYTE_SEL;
          bootState <= (wordIdx == 11'h0) ? boot_bus_pkg::B_IDLE : boot_bus_pkg::B_GAP;
        end
      endcase
    end
  end

  assign booting = ~inIdle;
  assign pramWrite = inWrite;
  assign pramAddr = wordIdx;
  assign pramData = wordBuf;

  // ----------------------------------------------------------------
  // bus request and grant
  // ----------------------------------------------------------------
  wire accessBusy = extAccessBusy | inAccess;
  wire next_grant = reqActive & (grantReg | ~accessBusy);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grantReg <= 1'b0;
    end else begin
      grantReg <= next_grant;
    end
  end

  // grant falls combinationally with the synchronised request
  assign busGranted = reqActive & (grantReg | coreReset);
  assign busGrant_n = ~busGranted;
  assign busDriveOe = ~busGranted;
  // only a stall signal; core state and serial ports are untouched
  assign coreHalt = busGranted & (~goModeEnable | extAccessReq | booting);
  assign busGrantHang_n = ~(busGranted & (extAccessReq | booting));
  // second half of a split instruction waits for the request to go
  assign extAccessAllow = ~reqActive & ~grantReg & inIdle;

  // ----------------------------------------------------------------
  // external pin drivers
  // ----------------------------------------------------------------
  logic [23:0] dataOeReg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extBus <= '{addr: 14'h0, data: 24'h0, bootSel_n: 1'b1, progSel_n: 1'b1,
                  dataSel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      dataOeReg <= 24'h0;
    end else if (inAccess) begin
      extBus <= '{addr: byteAddr[13:0], data: {byteAddr[15:14], 22'h0}, bootSel_n: 1'b0,
                  progSel_n: 1'b1, dataSel_n: 1'b1, rd_n: 1'b0, wr_n: 1'b1};
      dataOeReg <= boot_bus_pkg::BOOT_HI_OE;
    end else begin
      extBus <= '{addr: coreBus.addr, data: coreBus.data, bootSel_n: 1'b1, progSel_n: ~coreBus.progSel,
                  dataSel_n: ~coreBus.dataSel, rd_n: ~coreBus.rd, wr_n: ~coreBus.wr};
      dataOeReg <= coreBus.dataOe;
    end
  end

  assign extDataOe = dataOeReg & {24{busDriveOe}};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seqIdleRequest;
    reqActive && !accessBusy && !grantReg && !coreReset;
  endsequence

  sequence seqByteStart;
    inGap && canStart && bootWait == 3'h0;
  endsequence

  AST_GRANT_NEXT: assert property (seqIdleRequest ##1 reqActive |-> !busGrant_n && !busDriveOe)
    else $error("idle request not granted in the next cycle");
  AST_RELEASE_SAME: assert property (!reqActive |-> busGrant_n && busDriveOe)
    else $error("grant still high after request removed");
  AST_FLOAT_ON_GRANT: assert property (!busGrant_n |-> extDataOe == 24'h0)
    else $error("data pins driven while bus granted");
  AST_NO_GRANT_IN_BYTE: assert property (inAccess ##1 inAccess |-> !grantReg)
    else $error("grant taken in the middle of a boot byte");
  AST_WAIT_ZERO: assert property (seqByteStart |=> inAccess [*4] ##1 !inAccess)
    else $error("zero-wait boot byte not four cycles long");
  AST_BOOT_STROBE: assert property (inAccess ##1 inAccess |-> !extBus.bootSel_n && extBus.progSel_n
                                    && extBus.dataSel_n && !extBus.rd_n)
    else $error("boot access without boot strobe alone");
  AST_ADDR_SPLIT: assert property (inAccess ##1 inAccess |-> {extBus.data[23:22], extBus.addr}
                                   == $past(byteAddr) && dataOeReg == 24'hc00000)
    else $error("boot address not split over address and data pins");
  AST_RESET_PAGE0: assert property (strapStart |=> curPage == 3'h0 && lenPhase && byteAddr == 16'h0000)
    else $error("strap boot did not start at page zero length byte");
  AST_LEN_ZERO: assert property (inAccess && lenPhase && byteDone && bootByte == 8'h00
                                 |=> wordIdx == 11'h7 && byteAddr[12:0] == 13'h1f)
    else $error("zero page length does not give eight words");
  AST_HANG_GRANTED: assert property (!busGrantHang_n |-> !busGrant_n && coreHalt)
    else $error("hang asserted without grant");
  AST_RESET_GRANT: assert property (coreReset && reqActive |-> !busGrant_n)
    else $error("request in reset not granted in same cycle");
  AST_GO_RUNS: assert property (goModeEnable && !extAccessReq && !booting |-> !coreHalt)
    else $error("core halted in go mode without external access");

endmodule : eprom_boot_and_bus_grant

// *** eprom_bus_partner.sv ***
`timescale 1ns/1ps
module eprom_bus_partner #(
  parameter logic [7:0] LEN_PAGE0 = 8'h00,
  parameter logic [7:0] LEN_PAGE3 = 8'h01
) (
  input wire logic clk,
  input wire logic bootSel_n,
  input wire logic rd_n,
  input wire logic [15:0] byteAddr,
  output logic [23:0] memData
);
  // ----------------------------------------------------------------
  // byte-wide boot memory
  // ----------------------------------------------------------------
  // byte zero of each 8k page holds the length, the rest a pattern
  function automatic logic [7:0] romByte(input logic [15:0] a);
    if (a[12:0] != 13'h0) begin
      return a[7:0] ^ {a[15:13], a[12:8]} ^ 8'h5a;
    end
    return (a[15:13] == 3'h3) ? LEN_PAGE3 : LEN_PAGE0;
  endfunction : romByte

  logic [23:0] idleData;

  initial idleData = 24'h000000;
  // unselected or released lines toggle so no stale byte is mistaken for data
  always @(posedge clk) begin
    idleData <= ~idleData;
  end

  // asynchronous memory: the byte follows strobe and address with no clock
  assign memData = (!bootSel_n && !rd_n) ?
                   {idleData[23:16], romByte(byteAddr), idleData[7:0]} : idleData;
endmodule : eprom_bus_partner

// *** eprom_boot_and_bus_grant_tb.sv ***
`timescale 1ns/1ps
module eprom_boot_and_bus_grant_tb;
  logic clk, rst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic memoryMapSelect, bootModeSelect, busRequest_n, coreReset, goModeEnable, extAccessReq, extAccessBusy;
  logic [23:0] extDataIn, memData, extDataOe;
  boot_bus_pkg::core_bus_type coreBus;
  boot_bus_pkg::ext_bus_type extBus;
  logic busDriveOe, busGrant_n, busGrantHang_n, coreHalt, extAccessAllow, pramWrite, pramRelocated, booting;
  logic [10:0] pramAddr;
  logic [23:0] pramData;
  logic [13:0] pramBase, resetVector;
  int errCount = 0;
  int checkCount = 0;
  int lowRun = 0;
  int lastRun = 0;
  logic [34:0] wq[$];

  // data pins: device drives where enabled, memory elsewhere
  assign extDataIn = (extDataOe & extBus.data) | (~extDataOe & memData);

  eprom_boot_and_bus_grant i_dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .memoryMapSelect(memoryMapSelect), .bootModeSelect(bootModeSelect), .busRequest_n(busRequest_n),
    .extDataIn(extDataIn), .coreReset(coreReset), .goModeEnable(goModeEnable),
    .extAccessReq(extAccessReq), .extAccessBusy(extAccessBusy), .coreBus(coreBus), .extBus(extBus),
    .extDataOe(extDataOe), .busDriveOe(busDriveOe), .busGrant_n(busGrant_n), .busGrantHang_n(busGrantHang_n),
    .coreHalt(coreHalt), .extAccessAllow(extAccessAllow), .pramWrite(pramWrite), .pramAddr(pramAddr),
    .pramData(pramData), .pramRelocated(pramRelocated), .pramBase(pramBase), .resetVector(resetVector),
    .booting(booting)
  );

  eprom_bus_partner i_mem (
    .clk(clk),
    .bootSel_n(extBus.bootSel_n),
    .rd_n(extBus.rd_n),
    .byteAddr({extBus.data[23:22], extBus.addr}),
    .memData(memData)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (pramWrite === 1'b1) wq.push_back({pramAddr, pramData});
    if (extBus.bootSel_n === 1'b0) begin
      lowRun <= lowRun + 1;
    end else begin
      if (lowRun > 0) lastRun <= lowRun;
      lowRun <= 0;
    end
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task hang;
    errCount++;
    $display("ERROR t=%0t wait ran out", $time);
    close_out();
  endtask : hang

  task chk(input logic [34:0] seen, input logic [34:0] exp, input string what);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // counts falling edges until the level shows, bounded
  task automatic waitLevel(ref logic s, input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > lim) hang();
    end while (s !== lvl);
  endtask : waitLevel

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expResp);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    waitLevel(s_axi_awready, 1'b1, 50, n);
    @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    waitLevel(s_axi_bvalid, 1'b1, 50, n);
    chk(s_axi_bresp, expResp, "write response");
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    waitLevel(s_axi_arready, 1'b1, 50, n);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    waitLevel(s_axi_rvalid, 1'b1, 50, n);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : axiRead

  // ----------------------------------------------------------------
  // boot result
  // ----------------------------------------------------------------
  function automatic logic [7:0] byteVal(input logic [15:0] a);
    return a[7:0] ^ {a[15:13], a[12:8]} ^ 8'h5a;
  endfunction : byteVal

  function automatic logic [23:0] expWord(input int page, input int k);
    logic [15:0] b;
    b = 16'(page * 8192 + 4 * k);
    return {byteVal(b + 16'h1), byteVal(b + 16'h2), byteVal(b + 16'h3)};
  endfunction : expWord

  task automatic checkBoot(input int page, input int len, input int waitSt);
    int n;
    int words;
    waitLevel(booting, 1'b0, 30000, n);
    words = (len + 1) * 8;
    chk(wq.size(), words, "word count");
    for (int i = 0; i < words && i < wq.size(); i++) begin
      chk(wq[i], {11'(words - 1 - i), expWord(page, words - 1 - i)}, "loaded word");
    end
    chk(lastRun, waitSt + 4, "strobe length");
    wq.delete();
  endtask : checkBoot

  initial begin
    repeat (90000) @(posedge clk);
    hang();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n, m;
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {memoryMapSelect, bootModeSelect, coreReset, goModeEnable, extAccessReq, extAccessBusy} = '0;
    busRequest_n = 1'b1;
    coreBus = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    axiRead(boot_bus_pkg::OFFS_CTRL, d, r);
    chk(d[6:0], 7'h38, "control after reset");
    waitLevel(booting, 1'b1, 20, n);
    checkBoot(0, 0, 7);
    $display("strap boot test done");
    axiWrite(8'h40, 32'h0, boot_bus_pkg::RESP_SLVERR);
    axiRead(8'h40, d, r);
    chk({d, r}, {32'h0, boot_bus_pkg::RESP_SLVERR}, "unmapped read");
    // page 3, no wait states, force; a request lands in mid-boot
    axiWrite(boot_bus_pkg::OFFS_CTRL, 32'h43, boot_bus_pkg::RESP_OKAY);
    repeat (20) @(posedge clk);
    busRequest_n <= 1'b0;
    waitLevel(busGrant_n, 1'b0, 20, n);
    chk({busDriveOe, extDataOe}, 25'h0, "pins released");
    repeat (4) @(negedge clk);
    m = wq.size();
    repeat (30) @(negedge clk);
    chk({wq.size(), booting}, {m, 1'b1}, "boot paused");
    axiRead(boot_bus_pkg::OFFS_STATUS, d, r);
    chk({d[3:0], r}, {4'h3, boot_bus_pkg::RESP_OKAY}, "status in grant");
    @(posedge clk);
    busRequest_n <= 1'b1;
    waitLevel(busGrant_n, 1'b1, 20, n);
    chk(busDriveOe, 1'b1, "drivers back");
    checkBoot(3, 1, 0);
    $display("forced boot test done");
    @(posedge clk);
    busRequest_n <= 1'b0;
    waitLevel(busGrant_n, 1'b0, 20, n);
    chk({n, coreHalt, busGrantHang_n}, {32'd4, 2'b11}, "idle grant");
    @(posedge clk);
    goModeEnable <= 1'b1;
    @(negedge clk);
    chk({coreHalt, busGrantHang_n}, 2'b01, "go mode runs");
    @(posedge clk);
    extAccessReq <= 1'b1;
    @(negedge clk);
    chk({coreHalt, busGrantHang_n, extAccessAllow}, 3'b100, "blocked core");
    @(posedge clk);
    busRequest_n <= 1'b1;
    waitLevel(busGrant_n, 1'b1, 20, n);
    chk({busGrantHang_n, coreHalt, extAccessAllow}, 3'b100, "release");
    @(negedge clk);
    chk(extAccessAllow, 1'b1, "pending access resumes");
    @(posedge clk);
    extAccessReq <= 1'b0;
    extAccessBusy <= 1'b1;
    busRequest_n <= 1'b0;
    repeat (8) @(negedge clk);
    chk(busGrant_n, 1'b1, "grant held off");
    @(posedge clk);
    extAccessBusy <= 1'b0;
    waitLevel(busGrant_n, 1'b0, 3, n);
    chk(n, 2, "grant after access");
    @(posedge clk);
    busRequest_n <= 1'b1;
    coreReset <= 1'b1;
    waitLevel(busGrant_n, 1'b1, 20, n);
    @(posedge clk);
    busRequest_n <= 1'b0;
    waitLevel(busGrant_n, 1'b0, 20, n);
    chk(n, 3, "grant in core reset");
    @(posedge clk);
    busRequest_n <= 1'b1;
    coreReset <= 1'b0;
    $display("grant test done");
    @(posedge clk);
    rst_n <= 1'b0;
    memoryMapSelect <= 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(negedge clk);
    chk({pramRelocated, pramBase, resetVector, booting}, {1'b1, 14'h3800, 14'h0000, 1'b0}, "map");
    axiRead(boot_bus_pkg::OFFS_STATUS, d, r);
    chk({d[3:0], r}, {4'h4, boot_bus_pkg::RESP_OKAY}, "status map");
    $display("memory map test done");
    close_out();
  end
endmodule : eprom_boot_and_bus_grant_tb
